/* File: vtps_defines.svh */
// Constants of the video test pattern selection block.
// Assumes it is included by bare name from the package, the ramp and the top design file.
`ifndef VTPS_DEFINES_SVH
`define VTPS_DEFINES_SVH

// Register indices; the byte address is four times the index
`define VTPS_IDX_TXPWR 8'h63
`define VTPS_IDX_PATCTL 8'h64
`define VTPS_IDX_PATCFG 8'h65
`define VTPS_IDX_CUST_R 8'h70
`define VTPS_IDX_CUST_G 8'h71
`define VTPS_IDX_CUST_B 8'h72
`define VTPS_IDX_FRAMES 8'h73
`define VTPS_IDX_STATUS 8'h74

// Reset values
`define VTPS_RST_TXPWR 8'h00
`define VTPS_RST_PATCTL 8'h10
`define VTPS_RST_PATCFG 8'h00
`define VTPS_RST_CUST 8'h00
`define VTPS_RST_FRAMES 8'h01

// Field positions
`define VTPS_BIT_PWDN 0
`define VTPS_SEL_HI 7
`define VTPS_SEL_LO 4
`define VTPS_BIT_COMPL 3
`define VTPS_BIT_BARS 2
`define VTPS_BIT_BANDREV 1
`define VTPS_BIT_GEN_EN 0
`define VTPS_BIT_INVERT 1
`define VTPS_BIT_ASCROLL 0

// Select codes
`define VTPS_SEL_FIRST 4'h1
`define VTPS_SEL_LAST 4'he

// Ramp level count per colour channel and top ramp level
`define VTPS_LEVELS 16'h0100
`define VTPS_LEVEL_MAX 8'hff

`endif

/* File: vtps_pkg.sv */
// Types shared by the video test pattern selection block.
// Assumes vtps_defines.svh is on the include path.
package vtps_pkg;
  `include "vtps_defines.svh"

  // One pixel, eight bits per channel
  typedef struct packed {
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
  } vtps_rgb_t;

  // Fixed pattern select codes
  typedef enum logic [3:0] {
    VTPS_P_RSVD0 = 4'b0000,
    VTPS_P_WHITE = 4'b0001,
    VTPS_P_BLACK = 4'b0010,
    VTPS_P_RED = 4'b0011,
    VTPS_P_GREEN = 4'b0100,
    VTPS_P_BLUE = 4'b0101,
    VTPS_P_HR_W = 4'b0110,
    VTPS_P_HR_R = 4'b0111,
    VTPS_P_HR_G = 4'b1000,
    VTPS_P_HR_B = 4'b1001,
    VTPS_P_VR_W = 4'b1010,
    VTPS_P_VR_R = 4'b1011,
    VTPS_P_VR_G = 4'b1100,
    VTPS_P_VR_B = 4'b1101,
    VTPS_P_CUSTOM = 4'b1110,
    VTPS_P_RSVD15 = 4'b1111
  } vtps_sel_t;

  // Register write request from the bus front end
  typedef struct packed {
    logic stb;
    logic [7:0] idx;
    logic [7:0] data;
  } vtps_wr_t;
endpackage

/* File: vtps_ramp.sv */
// Even spread of 256 levels over a span of steps by error accumulation.
// Assumes the span is at least the level count and at most 2^W-1 steps.
`include "vtps_defines.svh"

module vtps_ramp #(
  parameter int W = 12
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic restart_i,
  input wire logic step_i,
  input wire logic [W-1:0] span_i,
  output logic [7:0] level_o
);
  import vtps_pkg::*;

  logic [W:0] acc_q; // Error accumulator
  logic [W:0] acc_sum; // Accumulator plus one step worth of levels
  logic [7:0] level_q; // Present level

  // One step adds levels, one level costs one span
  assign acc_sum = acc_q + (W+1)'(`VTPS_LEVELS);

  // Level and accumulator update
  always_ff @(posedge clk_i) begin
    if (rst_i || restart_i) begin
      acc_q <= '0;
      level_q <= '0;
    end else if (step_i) begin
      if (acc_sum >= {1'b0, span_i}) begin
        acc_q <= acc_sum - {1'b0, span_i};
        // Saturate so the last step never wraps to black
        if (level_q != `VTPS_LEVEL_MAX) begin
          level_q <= level_q + 8'h01;
        end
      end else begin
        acc_q <= acc_sum;
      end
    end
  end

  assign level_o = level_q;
endmodule

/* File: vtps_wb_slave.sv */
// Classic Wishbone slave front end: decode, acknowledge, read data latch.
// Assumes a single-cycle classic master that holds its request until ack.
module vtps_wb_slave (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [9:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic [7:0] rd_idx_o,
  input wire logic [7:0] rd_val_i,
  output vtps_pkg::vtps_wr_t wr_o
);
  import vtps_pkg::*;

  logic ack_q; // Acknowledge, one cycle after the request
  logic [31:0] dat_q; // Latched read data

  assign rd_idx_o = adr_i[9:2];

  // Acknowledge every request once, then drop it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= cyc_i && stb_i && !ack_q;
    end
  end

  // Read data captured with the acknowledge; upper bits read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= '0;
    end else if (cyc_i && stb_i && !ack_q) begin
      dat_q <= {24'h000000, rd_val_i};
    end
  end

  // Write lands at the edge that sees ack high, low byte lane only
  assign wr_o.stb = cyc_i && stb_i && we_i && ack_q && sel_i[0];
  assign wr_o.idx = adr_i[9:2];
  assign wr_o.data = dat_i[7:0];

  assign ack_o = ack_q;
  assign dat_o = dat_q;
endmodule

/* File: vtps_top.sv */
// Test pattern selection and loop-through transmitter power-down control.
// Assumes external timing: active enable, frame start pulse and active sizes
// arrive synchronous to clk_i; registers are reached over classic Wishbone.
//
// The Wishbone slave port is this design's own decision.

`include "vtps_defines.svh"

module vtps_top #(
  parameter int W = 12
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic de_i,
  input wire logic frame_start_i,
  input wire logic [W-1:0] h_active_i,
  input wire logic [W-1:0] v_active_i,
  input wire vtps_pkg::vtps_rgb_t video_i,
  output vtps_pkg::vtps_rgb_t pixel_o,
  output logic pixel_de_o,
  output logic pattern_active_o,
  output logic loopthru_tx_powerdown_o
);
  import vtps_pkg::*;

  // Reset images, held as constants so single bits can be picked out
  localparam logic [7:0] RST_TXPWR = `VTPS_RST_TXPWR;
  localparam logic [7:0] RST_PATCFG = `VTPS_RST_PATCFG;

  // Register state
  logic loopthru_tx_powerdown_q; // Monitor transmitter power-down
  logic [7:0] test_pattern_control_q; // Pattern control register
  logic pattern_invert_q; // Inverted colour variant
  logic auto_scroll_enable_q; // Automatic pattern stepping
  logic [7:0] custom_red_level_q; // Custom colour, red
  logic [7:0] custom_green_level_q; // Custom colour, green
  logic [7:0] custom_blue_level_q; // Custom colour, blue
  logic [7:0] scroll_frames_q; // Frames per pattern in auto-scroll

  // Control fields
  logic [3:0] fixed_pattern_select;
  logic compliance_pattern_enable;
  logic color_bar_enable;
  logic band_order_reverse;
  logic pattern_gen_enable;

  // Bus front end
  vtps_wr_t wr;
  logic [7:0] rd_idx;
  logic [7:0] rd_val;

  // Auto-scroll state
  logic [3:0] scroll_sel_q; // Pattern shown by auto-scroll
  logic [7:0] frame_cnt_q; // Frames shown of the present pattern
  logic [3:0] active_sel; // Select code in effect

  // Ramp timing
  logic de_q; // Enable one cycle late, for edges
  logic line_start;
  logic line_end;
  logic [7:0] h_level;
  logic [7:0] v_level;

  // Pattern assembly
  vtps_rgb_t fixed_px;
  vtps_rgb_t bar_px;
  vtps_rgb_t band_px;
  vtps_rgb_t chosen_px;
  vtps_rgb_t pixel_q;
  logic pixel_de_q;

  assign fixed_pattern_select = test_pattern_control_q[`VTPS_SEL_HI:`VTPS_SEL_LO];
  assign compliance_pattern_enable = test_pattern_control_q[`VTPS_BIT_COMPL];
  assign color_bar_enable = test_pattern_control_q[`VTPS_BIT_BARS];
  assign band_order_reverse = test_pattern_control_q[`VTPS_BIT_BANDREV];
  assign pattern_gen_enable = test_pattern_control_q[`VTPS_BIT_GEN_EN];

  // Register access front end
  vtps_wb_slave u_wb (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cyc_i(wb_cyc_i),
    .stb_i(wb_stb_i),
    .we_i(wb_we_i),
    .adr_i(wb_adr_i),
    .sel_i(wb_sel_i),
    .dat_i(wb_dat_i),
    .dat_o(wb_dat_o),
    .ack_o(wb_ack_o),
    .rd_idx_o(rd_idx),
    .rd_val_i(rd_val),
    .wr_o(wr)
  );

  // Power-down register; only bit 0 is writable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      loopthru_tx_powerdown_q <= RST_TXPWR[`VTPS_BIT_PWDN];
    end else if (wr.stb && wr.idx == `VTPS_IDX_TXPWR) begin
      loopthru_tx_powerdown_q <= wr.data[`VTPS_BIT_PWDN];
    end
  end

  // Pattern control register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      test_pattern_control_q <= `VTPS_RST_PATCTL;
    end else if (wr.stb && wr.idx == `VTPS_IDX_PATCTL) begin
      test_pattern_control_q <= wr.data;
    end
  end

  // Pattern configuration register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pattern_invert_q <= RST_PATCFG[`VTPS_BIT_INVERT];
      auto_scroll_enable_q <= RST_PATCFG[`VTPS_BIT_ASCROLL];
    end else if (wr.stb && wr.idx == `VTPS_IDX_PATCFG) begin
      pattern_invert_q <= wr.data[`VTPS_BIT_INVERT];
      auto_scroll_enable_q <= wr.data[`VTPS_BIT_ASCROLL];
    end
  end

  // Custom colour registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      custom_red_level_q <= `VTPS_RST_CUST;
      custom_green_level_q <= `VTPS_RST_CUST;
      custom_blue_level_q <= `VTPS_RST_CUST;
    end else if (wr.stb) begin
      if (wr.idx == `VTPS_IDX_CUST_R) begin
        custom_red_level_q <= wr.data;
      end
      if (wr.idx == `VTPS_IDX_CUST_G) begin
        custom_green_level_q <= wr.data;
      end
      if (wr.idx == `VTPS_IDX_CUST_B) begin
        custom_blue_level_q <= wr.data;
      end
    end
  end

  // Auto-scroll frame count register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scroll_frames_q <= `VTPS_RST_FRAMES;
    end else if (wr.stb && wr.idx == `VTPS_IDX_FRAMES) begin
      scroll_frames_q <= wr.data;
    end
  end

  // Read multiplexer; unmapped indices read zero
  always_comb begin
    rd_val = 8'h00;
    unique case (rd_idx)
      `VTPS_IDX_TXPWR: rd_val = {7'h00, loopthru_tx_powerdown_q};
      `VTPS_IDX_PATCTL: rd_val = test_pattern_control_q;
      `VTPS_IDX_PATCFG: rd_val = {6'h00, pattern_invert_q, auto_scroll_enable_q};
      `VTPS_IDX_CUST_R: rd_val = custom_red_level_q;
      `VTPS_IDX_CUST_G: rd_val = custom_green_level_q;
      `VTPS_IDX_CUST_B: rd_val = custom_blue_level_q;
      `VTPS_IDX_FRAMES: rd_val = scroll_frames_q;
      // Live state: pattern in effect, generator running
      `VTPS_IDX_STATUS: rd_val = {active_sel, 3'h0, pattern_active_o};
      default: rd_val = 8'h00;
    endcase
  end

  // Auto-scroll: step through codes 1..14 every programmed frame count
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scroll_sel_q <= `VTPS_SEL_FIRST;
      frame_cnt_q <= '0;
    end else if (!auto_scroll_enable_q || !pattern_gen_enable) begin
      // Hold the scroll start at the first code when scrolling is off
      scroll_sel_q <= `VTPS_SEL_FIRST;
      frame_cnt_q <= '0;
    end else if (frame_start_i) begin
      if (frame_cnt_q + 8'h01 >= scroll_frames_q) begin
        frame_cnt_q <= '0;
        if (scroll_sel_q == `VTPS_SEL_LAST) begin
          scroll_sel_q <= `VTPS_SEL_FIRST;
        end else begin
          scroll_sel_q <= scroll_sel_q + 4'h1;
        end
      end else begin
        frame_cnt_q <= frame_cnt_q + 8'h01;
      end
    end
  end

  // Scrolling overrides the fixed select field
  assign active_sel = auto_scroll_enable_q ? scroll_sel_q : fixed_pattern_select;

  // Line edges from the active enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      de_q <= 1'b0;
    end else begin
      de_q <= de_i;
    end
  end

  assign line_start = de_i && !de_q;
  assign line_end = !de_i && de_q;

  // Horizontal ramp: restarts each line, steps each active pixel
  // Stepping on the live enable lets the last pixel of a line reach full scale
  vtps_ramp #(.W(W)) u_hramp (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .restart_i(line_end || frame_start_i),
    .step_i(de_i),
    .span_i(h_active_i),
    .level_o(h_level)
  );

  // Vertical ramp: restarts each frame, steps each active line
  vtps_ramp #(.W(W)) u_vramp (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .restart_i(frame_start_i),
    .step_i(line_end),
    .span_i(v_active_i),
    .level_o(v_level)
  );

  // Fixed pattern colours before inversion
  always_comb begin
    fixed_px = '0;
    unique case (active_sel)
      VTPS_P_WHITE: fixed_px = '{8'hff, 8'hff, 8'hff};
      VTPS_P_BLACK: fixed_px = '{8'h00, 8'h00, 8'h00};
      VTPS_P_RED: fixed_px = '{8'hff, 8'h00, 8'h00};
      VTPS_P_GREEN: fixed_px = '{8'h00, 8'hff, 8'h00};
      VTPS_P_BLUE: fixed_px = '{8'h00, 8'h00, 8'hff};
      VTPS_P_HR_W: fixed_px = '{h_level, h_level, h_level};
      VTPS_P_HR_R: fixed_px = '{h_level, 8'h00, 8'h00};
      VTPS_P_HR_G: fixed_px = '{8'h00, h_level, 8'h00};
      VTPS_P_HR_B: fixed_px = '{8'h00, 8'h00, h_level};
      VTPS_P_VR_W: fixed_px = '{v_level, v_level, v_level};
      VTPS_P_VR_R: fixed_px = '{v_level, 8'h00, 8'h00};
      VTPS_P_VR_G: fixed_px = '{8'h00, v_level, 8'h00};
      VTPS_P_VR_B: fixed_px = '{8'h00, 8'h00, v_level};
      VTPS_P_CUSTOM: begin
        fixed_px = '{custom_red_level_q, custom_green_level_q, custom_blue_level_q};
      end
      // Reserved codes show black
      default: fixed_px = '0;
    endcase
  end

  // Eight bars across the line, taken from the top ramp bits
  always_comb begin
    bar_px = '0;
    unique case (h_level[7:5])
      3'h0: bar_px = '{8'hff, 8'hff, 8'hff};
      3'h1: bar_px = '{8'hff, 8'hff, 8'h00};
      3'h2: bar_px = '{8'h00, 8'hff, 8'hff};
      3'h3: bar_px = '{8'h00, 8'hff, 8'h00};
      3'h4: bar_px = '{8'hff, 8'h00, 8'hff};
      3'h5: bar_px = '{8'hff, 8'h00, 8'h00};
      3'h6: bar_px = '{8'h00, 8'h00, 8'hff};
      3'h7: bar_px = '{8'h00, 8'h00, 8'h00};
    endcase
  end

  // Four quadrant bands: top left, top right, bottom left, bottom right
  always_comb begin
    band_px = '0;
    unique case ({v_level[7], h_level[7]})
      2'b00: begin
        // Top left: yellow, or blue when reversed
        band_px = band_order_reverse ? vtps_rgb_t'{8'h00, 8'h00, 8'hff}
                                     : vtps_rgb_t'{8'hff, 8'hff, 8'h00};
      end
      2'b01: band_px = '{8'h00, 8'hff, 8'hff};
      2'b10: begin
        // Bottom left: blue, or yellow when reversed
        band_px = band_order_reverse ? vtps_rgb_t'{8'hff, 8'hff, 8'h00}
                                     : vtps_rgb_t'{8'h00, 8'h00, 8'hff};
      end
      2'b11: band_px = '{8'hff, 8'h00, 8'h00};
    endcase
  end

  // Source priority: compliance, then bars, then select field
  always_comb begin
    chosen_px = fixed_px;
    if (compliance_pattern_enable) begin
      chosen_px = band_px;
    end else if (color_bar_enable) begin
      chosen_px = bar_px;
    end
  end

  // Output pixel: pattern when enabled, else the incoming video
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pixel_q <= '0;
      pixel_de_q <= 1'b0;
    end else begin
      pixel_de_q <= de_i;
      if (!pattern_gen_enable) begin
        pixel_q <= video_i;
      end else if (!de_i) begin
        pixel_q <= '0; // Blanking stays black
      end else if (pattern_invert_q) begin
        pixel_q <= ~chosen_px;
      end else begin
        pixel_q <= chosen_px;
      end
    end
  end

  assign pixel_o = pixel_q;
  assign pixel_de_o = pixel_de_q;
  assign pattern_active_o = pattern_gen_enable;
  assign loopthru_tx_powerdown_o = loopthru_tx_powerdown_q;
endmodule

/* File: vtps_top_chk.sv */
// Checker for the pattern select block, watching only top-level ports.
// Assumes it is bound into vtps_top from the bench top file.
module vtps_top_chk #(
  parameter int W = 12
) (
  input logic clk_i,
  input logic rst_i,
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_we_i,
  input logic [9:0] wb_adr_i,
  input logic [3:0] wb_sel_i,
  input logic [31:0] wb_dat_i,
  input logic wb_ack_o,
  input logic de_i,
  input vtps_pkg::vtps_rgb_t video_i,
  input vtps_pkg::vtps_rgb_t pixel_o,
  input logic pixel_de_o,
  input logic pattern_active_o,
  input logic loopthru_tx_powerdown_o
);
  import vtps_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Request present on the bus
  logic req;
  // Accepted writes to power and control registers
  logic wr_pwr;
  logic wr_ctl;
  assign req = wb_cyc_i && wb_stb_i;
  assign wr_pwr = req && wb_we_i && wb_ack_o && wb_sel_i[0] && wb_adr_i[9:2] == 8'h63;
  assign wr_ctl = req && wb_we_i && wb_ack_o && wb_sel_i[0] && wb_adr_i[9:2] == 8'h64;
  ack_timing_a: assert property (req && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(req))
    else $error("ack without request");
  pwdn_write_a: assert property (wr_pwr |=> loopthru_tx_powerdown_o == $past(wb_dat_i[0]))
    else $error("power-down output not written");
  pwdn_hold_a: assert property (!wr_pwr |=> $stable(loopthru_tx_powerdown_o))
    else $error("power-down output changed without write");
  gen_write_a: assert property (wr_ctl |=> pattern_active_o == $past(wb_dat_i[0]))
    else $error("generator enable not written");
  gen_hold_a: assert property (!wr_ctl |=> $stable(pattern_active_o))
    else $error("generator enable changed without write");
  de_follow_a: assert property (!$past(rst_i) |-> pixel_de_o == $past(de_i))
    else $error("pixel enable not one cycle behind");
  video_pass_a: assert property (!$past(rst_i) && !$past(pattern_active_o) |->
    pixel_o == $past(video_i))
    else $error("video not passed through while generator off");
  reset_low_a: assert property ($fell(rst_i) |-> !loopthru_tx_powerdown_o && !pattern_active_o)
    else $error("outputs not cleared by reset");
endmodule

/* File: tb_vtps_top.sv */
// Self-checking bench for the pattern select block.
// Assumes vtps_pkg, vtps_top and vtps_top_chk are compiled before it.
module tb_vtps_top;
  timeunit 1ns;
  timeprecision 1ps;
  import vtps_pkg::*;
  localparam int HA = 256;
  // Rows: control, config, first pixel, last pixel of one line
  localparam logic [63:0] ROWS [0:31] = '{
    64'h1000_123456_123456, 64'h1100_ffffff_ffffff, 64'h2100_000000_000000,
    64'h3100_ff0000_ff0000, 64'h4100_00ff00_00ff00, 64'h5100_0000ff_0000ff,
    64'h1102_000000_000000, 64'h2102_ffffff_ffffff, 64'h3102_00ffff_00ffff,
    64'h4102_ff00ff_ff00ff, 64'h5102_ffff00_ffff00, 64'h6100_000000_ffffff,
    64'h7100_000000_ff0000, 64'h8100_000000_00ff00, 64'h9100_000000_0000ff,
    64'h6102_ffffff_000000, 64'h7102_ffffff_00ffff, 64'h8102_ffffff_ff00ff,
    64'h9102_ffffff_ffff00, 64'ha100_000000_000000, 64'ha102_ffffff_ffffff,
    64'h0100_000000_000000, 64'hf100_000000_000000, 64'he100_3c5a96_3c5a96,
    64'he102_c3a569_c3a569, 64'h1500_ffffff_000000, 64'h3500_ffffff_000000,
    64'h1502_000000_ffffff, 64'h1900_ffff00_00ffff, 64'h1b00_0000ff_00ffff,
    64'h1d00_ffff00_00ffff, 64'h3900_ffff00_00ffff};
  // Reset values: index then value
  localparam logic [15:0] RV [0:6] = '{16'h6300, 16'h6410, 16'h6500, 16'h7000,
    16'h7100, 16'h7200, 16'h7301};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [9:0] wb_adr_i = 10'h000;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic de_i = 1'b0, frame_start_i = 1'b0, pixel_de_o, pattern_active_o, pwdn;
  vtps_rgb_t video_i = 24'h123456, pixel_o, first_px, last_px;
  int fail_count = 0, num_checks = 0, pcnt = 0;
  logic [11:0] h_act = 12'h100;
  // Free-running 40 MHz clock
  always #12.5 clk_i = ~clk_i;
  vtps_top #(.W(12)) vtps_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .de_i(de_i),
    .frame_start_i(frame_start_i), .h_active_i(h_act), .v_active_i(12'h100),
    .video_i(video_i), .pixel_o(pixel_o), .pixel_de_o(pixel_de_o),
    .pattern_active_o(pattern_active_o), .loopthru_tx_powerdown_o(pwdn));
  // Compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Classic single cycle; entered just after a rising edge
  task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] wd,
      input logic [3:0] sel = 4'hf);
    int t;
    t = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= sel;
    wb_dat_i <= {24'h0, wd};
    // Sample ack at each rising edge; take the answer at the edge that sees it
    do begin
      @(posedge clk_i);
      t++;
    end while (wb_ack_o !== 1'b1 && t < 50);
    if (wb_ack_o !== 1'b1) check(32'h1, 32'h0);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    wb(1'b1, idx, wd);
  endtask
  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    wb(1'b0, idx, 8'h00);
    check(rd, {24'h0, exp});
  endtask
  // One frame start, then a single active line
  task automatic run_line(input int n = HA);
    frame_start_i <= 1'b1;
    @(posedge clk_i);
    frame_start_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    de_i <= 1'b1;
    repeat (n) @(posedge clk_i);
    de_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  // Capture first and last output pixel of the line mid-cycle
  always @(negedge clk_i) begin
    if (frame_start_i) pcnt = 0;
    if (pixel_de_o === 1'b1) begin
      if (pcnt == 0) first_px = pixel_o;
      last_px = pixel_o;
      pcnt++;
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Watchdog well beyond the expected run of some 9700 cycles
  initial begin
    repeat (60000) @(posedge clk_i);
    fail_count++;
    $display("BAD %0t watchdog expired", $time);
    report_and_stop();
  end
  // Main sequence
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wr(8'h63, 8'h01);
    check(pwdn, 1'b1);
    wr(8'h70, 8'h3c);
    wr(8'h71, 8'h5a);
    wr(8'h72, 8'h96);
    foreach (ROWS[i]) begin
      wr(8'h65, ROWS[i][55:48]);
      wr(8'h64, ROWS[i][63:56]);
      run_line();
      check(first_px, ROWS[i][47:24]);
      check(last_px, ROWS[i][23:0]);
      check(pcnt, HA);
    end
    $display("done: pattern table");
    // Wider line: the ramp must still run from black to full white
    h_act <= 12'h200;
    wr(8'h64, 8'h61);
    run_line(2 * HA);
    check(first_px, 32'h0);
    check(last_px, 32'hffffff);
    check(pcnt, 2 * HA);
    h_act <= 12'h100;
    $display("done: wide ramp");
    // Auto-scroll overrides the select field, then steps per frame
    wr(8'h64, 8'h31);
    wr(8'h65, 8'h01);
    rdchk(8'h74, 8'h11);
    run_line();
    run_line();
    wb(1'b0, 8'h74, 8'h00);
    num_checks++;
    if (rd[7:4] === 4'h1 || $isunknown(rd)) begin
      fail_count++;
      $display("BAD %0t scroll did not step", $time);
    end
    wr(8'h65, 8'h00);
    rdchk(8'h74, 8'h31);
    $display("done: auto-scroll");
    // Byte lane zero off, unmapped index, readback
    wb(1'b1, 8'h64, 8'h00, 4'he);
    rdchk(8'h64, 8'h31);
    check(pattern_active_o, 1'b1);
    wr(8'h10, 8'hff);
    rdchk(8'h10, 8'h00);
    rdchk(8'h70, 8'h3c);
    wr(8'h63, 8'h00);
    check(pwdn, 1'b0);
    $display("done: register access");
    // Second reset in mid-run
    rst_i <= 1'b1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check(pwdn, 1'b0);
    check(pattern_active_o, 1'b0);
    foreach (RV[i]) rdchk(RV[i][15:8], RV[i][7:0]);
    $display("done: reset values");
    report_and_stop();
  end
endmodule
bind vtps_top vtps_top_chk #(.W(W)) vtps_top_chk_inst (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .de_i(de_i),
  .video_i(video_i), .pixel_o(pixel_o), .pixel_de_o(pixel_de_o),
  .pattern_active_o(pattern_active_o), .loopthru_tx_powerdown_o(loopthru_tx_powerdown_o));
